// File: design/sram_port_pkg.sv
// Constants and types for the pipelined synchronous SRAM port.
// Assumes one clock domain; the memory array lives in the core module.
package sram_port_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W   = 17;
  localparam int LANES    = 4;
  localparam int LANE_W   = 8;
  localparam int DATA_W   = LANES * LANE_W;
  localparam int DEPTH    = 1 << ADDR_W;

  // ----------------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------------
  localparam logic [1:0] SYNC_RST      = 2'h0;
  localparam logic [1:0] SLEEP_CYCLES  = 2'h2;
  localparam logic [1:0] BURST_RST     = 2'h0;

  // Pipeline slot contents
  typedef enum logic [1:0] {
    SLOT_IDLE,
    SLOT_READ,
    SLOT_WRITE
  } slot_kind_t;

endpackage

// File: design/sram_array.sv
// Memory array with per-lane write strobes, data plus one parity bit per lane.
// Assumes the port controller may give one write and one read in the same cycle.
`timescale 1ns/10ps
module sram_array
  import sram_port_pkg::*;
(
  input  wire logic              sys_clk_i,   // System clock
  input  wire logic              wr_en_i,     // Write strobe
  input  wire logic [LANES-1:0]  lane_en_i,   // Lane select, high active
  input  wire logic [ADDR_W-1:0] addr_i,      // Write word address
  input  wire logic [ADDR_W-1:0] rd_addr_i,   // Read word address
  input  wire logic [DATA_W-1:0] wdata_i,     // Write data
  input  wire logic [LANES-1:0]  wpar_i,      // Write parity
  output logic      [DATA_W-1:0] rdata_o,     // Read data, combinational
  output logic      [LANES-1:0]  rpar_o       // Read parity, combinational
);

  // ----------------------------------------------------------------
  // Storage, one array per lane
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : g_lane
      logic [LANE_W:0] mem [DEPTH];
      // Parity bit is gated by the same strobe as its byte
      always_ff @(posedge sys_clk_i) begin
        if (wr_en_i && lane_en_i[g]) begin
          mem[addr_i] <= {wpar_i[g], wdata_i[g*LANE_W +: LANE_W]};
        end
      end
      // Separate read address so a read can follow a write at once
      assign rdata_o[g*LANE_W +: LANE_W] = mem[rd_addr_i][LANE_W-1:0];
      assign rpar_o[g]                   = mem[rd_addr_i][LANE_W];
    end
  endgenerate

endmodule

// File: design/sram_port.sv
// Synchronous pipelined burst SRAM port with common data and parity lines.
// Assumes a controller on sys_clk_i; oe_n and sleep are off-domain pins.
`timescale 1ns/10ps
module sram_port
  import sram_port_pkg::*;
(
  input  wire logic              sys_clk_i,          // 250 MHz clock
  input  wire logic              rst_n_i,            // Async reset, active low
  input  wire logic              clock_qualify_n_i,  // Clock qualify, active low
  input  wire logic              chip_select_low_a_i,// Chip select, active low
  input  wire logic              chip_select_high_i, // Chip select, active high
  input  wire logic              chip_select_low_b_i,// Chip select, active low
  input  wire logic              advance_or_load_i,  // High advance, low load
  input  wire logic              write_n_i,          // Write enable, active low
  input  wire logic [LANES-1:0]  byte_lane_write_n_i,// Byte strobes, active low
  input  wire logic [ADDR_W-1:0] addr_i,             // Address, bits 1:0 burst
  input  wire logic              output_enable_n_i,  // Async output enable
  input  wire logic              burst_order_i,      // Strap, low linear
  input  wire logic              sleep_request_i,    // Async sleep, active high
  input  wire logic [DATA_W-1:0] data_lines_i,       // Data lines in
  output logic      [DATA_W-1:0] data_lines_o,       // Data lines out
  output logic                   data_lines_oe_n_o,  // Data drive, low drives
  input  wire logic [LANES-1:0]  parity_lines_i,     // Parity lines in
  output logic      [LANES-1:0]  parity_lines_o,     // Parity lines out
  output logic                   parity_lines_oe_n_o // Parity drive, low drives
);

  // ----------------------------------------------------------------
  // Pin synchronisers for off-domain inputs
  // ----------------------------------------------------------------
  logic [2:0] oe_sync_reg;
  logic [2:0] sleep_sync_reg;
  logic [2:0] strap_sync_reg;
  logic       oe_n_reg;
  logic       sleep_reg;
  logic       strap_reg;

  // Three-stage chains; a level counts once stages two and three agree
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      oe_sync_reg    <= 3'h7;
      sleep_sync_reg <= 3'h0;
      strap_sync_reg <= 3'h7;
    end else begin
      oe_sync_reg    <= {oe_sync_reg[1:0], output_enable_n_i};
      sleep_sync_reg <= {sleep_sync_reg[1:0], sleep_request_i};
      strap_sync_reg <= {strap_sync_reg[1:0], burst_order_i};
    end
  end

  // Filtered levels
  wire oe_agree    = (oe_sync_reg[2] == oe_sync_reg[1]);
  wire sleep_agree = (sleep_sync_reg[2] == sleep_sync_reg[1]);
  wire strap_agree = (strap_sync_reg[2] == strap_sync_reg[1]);

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      oe_n_reg  <= 1'h1;
      sleep_reg <= 1'h0;
      strap_reg <= 1'h1;
    end else begin
      if (oe_agree) oe_n_reg <= oe_sync_reg[2];
      if (sleep_agree) sleep_reg <= sleep_sync_reg[2];
      if (strap_agree) strap_reg <= strap_sync_reg[2];
    end
  end

  // ----------------------------------------------------------------
  // Sleep entry and exit delay
  // ----------------------------------------------------------------
  logic [1:0] sleep_cnt_reg;
  logic       asleep_reg;
  wire        sleep_step = (sleep_reg != asleep_reg);

  // Sleep takes effect after a fixed count of cycles either way
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sleep_cnt_reg <= SYNC_RST;
      asleep_reg    <= 1'h0;
    end else if (!sleep_step) begin
      sleep_cnt_reg <= SYNC_RST;
    end else if (sleep_cnt_reg == SLEEP_CYCLES - 2'h1) begin
      sleep_cnt_reg <= SYNC_RST;
      asleep_reg    <= sleep_reg;
    end else begin
      sleep_cnt_reg <= sleep_cnt_reg + 2'h1;
    end
  end

  // ----------------------------------------------------------------
  // Input registers
  // ----------------------------------------------------------------
  logic              qual_n_reg;
  logic              cs_a_n_reg;
  logic              cs_h_reg;
  logic              cs_b_n_reg;
  logic              adv_reg;
  logic              wr_n_reg;
  logic [LANES-1:0]  bw_n_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [DATA_W-1:0] din_reg;
  logic [LANES-1:0]  pin_reg;

  // Every synchronous pin is captured on the rising edge
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      qual_n_reg <= 1'h1;
      cs_a_n_reg <= 1'h1;
      cs_h_reg   <= 1'h0;
      cs_b_n_reg <= 1'h1;
      adv_reg    <= 1'h0;
      wr_n_reg   <= 1'h1;
      bw_n_reg   <= 4'hF;
      addr_reg   <= '0;
      din_reg    <= '0;
      pin_reg    <= '0;
    end else begin
      qual_n_reg <= clock_qualify_n_i;
      cs_a_n_reg <= chip_select_low_a_i;
      cs_h_reg   <= chip_select_high_i;
      cs_b_n_reg <= chip_select_low_b_i;
      adv_reg    <= advance_or_load_i;
      wr_n_reg   <= write_n_i;
      bw_n_reg   <= byte_lane_write_n_i;
      addr_reg   <= addr_i;
      din_reg    <= data_lines_i;
      pin_reg    <= parity_lines_i;
    end
  end

  // ----------------------------------------------------------------
  // Command decode on the captured inputs
  // ----------------------------------------------------------------
  wire run       = !qual_n_reg && !asleep_reg;
  wire selected  = !cs_a_n_reg && cs_h_reg && !cs_b_n_reg;
  wire do_load   = run && !adv_reg;
  wire do_adv    = run && adv_reg;
  wire start_rd  = do_load && selected && wr_n_reg;
  wire start_wr  = do_load && selected && !wr_n_reg;
  wire deselect  = do_load && !selected;

  // ----------------------------------------------------------------
  // Burst address state
  // ----------------------------------------------------------------
  logic [ADDR_W-1:0] base_reg;
  logic [1:0]        step_reg;
  logic              interleave_reg;
  slot_kind_t        burst_kind_reg;

  // Burst sequence over the two low bits only, wrapping in four
  wire [1:0] step_next = step_reg + 2'h1;
  wire [1:0] lin_low   = base_reg[1:0] + step_next;
  wire [1:0] ilv_low   = base_reg[1:0] ^ step_next;
  wire [1:0] adv_low   = interleave_reg ? ilv_low : lin_low;

  // Load on a start, step on advance, hold with qualify high
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      base_reg       <= '0;
      step_reg       <= BURST_RST;
      interleave_reg <= 1'h1;
      burst_kind_reg <= SLOT_IDLE;
    end else if (do_load) begin
      base_reg       <= addr_reg;
      step_reg       <= BURST_RST;
      interleave_reg <= strap_reg;
      burst_kind_reg <= start_wr ? SLOT_WRITE : (start_rd ? SLOT_READ : SLOT_IDLE);
    end else if (do_adv) begin
      step_reg       <= step_next;
    end
  end

  // Address and kind of the access issued this cycle
  wire [ADDR_W-1:0] issue_addr = do_load ? addr_reg : {base_reg[ADDR_W-1:2], adv_low};
  wire slot_kind_t  issue_kind = do_load ? (start_wr ? SLOT_WRITE :
                                 (start_rd ? SLOT_READ : SLOT_IDLE))
                               : (do_adv ? burst_kind_reg : SLOT_IDLE);

  // ----------------------------------------------------------------
  // Two-stage command pipeline
  // ----------------------------------------------------------------
  slot_kind_t        s1_kind_reg;
  logic [ADDR_W-1:0] s1_addr_reg;
  logic [LANES-1:0]  s1_bw_n_reg;
  slot_kind_t        s2_kind_reg;
  logic [ADDR_W-1:0] s2_addr_reg;
  logic [LANES-1:0]  s2_bw_n_reg;
  logic              s1_after_desel_reg;
  logic              prev_desel_reg;

  // Commands act on the bus one and two cycles later
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_kind_reg        <= SLOT_IDLE;
      s1_addr_reg        <= '0;
      s1_bw_n_reg        <= 4'hF;
      s2_kind_reg        <= SLOT_IDLE;
      s2_addr_reg        <= '0;
      s2_bw_n_reg        <= 4'hF;
      s1_after_desel_reg <= 1'h0;
      prev_desel_reg     <= 1'h1;
    end else if (run) begin
      s1_kind_reg        <= issue_kind;
      s1_addr_reg        <= issue_addr;
      s1_bw_n_reg        <= bw_n_reg;
      s2_kind_reg        <= s1_kind_reg;
      s2_addr_reg        <= s1_addr_reg;
      s2_bw_n_reg        <= s1_bw_n_reg;
      s1_after_desel_reg <= prev_desel_reg && (issue_kind != SLOT_IDLE);
      prev_desel_reg     <= (issue_kind == SLOT_IDLE) || deselect;
    end
  end

  // ----------------------------------------------------------------
  // Array access
  // ----------------------------------------------------------------
  // Write lands with the data sampled two edges after the address
  wire              arr_wr   = run && (s2_kind_reg == SLOT_WRITE);
  wire [LANES-1:0]  arr_lane = ~s2_bw_n_reg;
  wire [ADDR_W-1:0] arr_addr = s2_addr_reg;
  wire              fwd_hit  = arr_wr && (s2_addr_reg == s1_addr_reg);
  logic [DATA_W-1:0] arr_rdata;
  logic [LANES-1:0]  arr_rpar;
  logic [DATA_W-1:0] rd_word;
  logic [LANES-1:0]  rd_par;

  sram_array u_array (
    .sys_clk_i (sys_clk_i),
    .wr_en_i   (arr_wr),
    .lane_en_i (arr_lane),
    .addr_i    (arr_addr),
    .rd_addr_i (s1_addr_reg),
    .wdata_i   (din_reg),
    .wpar_i    (pin_reg),
    .rdata_o   (arr_rdata),
    .rpar_o    (arr_rpar)
  );

  // A read right behind a write to the same word sees the new bytes
  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : g_fwd
      wire take = fwd_hit && arr_lane[g];
      assign rd_word[g*LANE_W +: LANE_W] = take ? din_reg[g*LANE_W +: LANE_W]
                                                : arr_rdata[g*LANE_W +: LANE_W];
      assign rd_par[g] = take ? pin_reg[g] : arr_rpar[g];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Output register and drive control
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] dout_reg;
  logic [LANES-1:0]  pout_reg;
  logic              drive_reg;

  // Read data and parity leave through a register
  wire rd_ready = (s1_kind_reg == SLOT_READ);
  wire drive_next = rd_ready && !s1_after_desel_reg;

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dout_reg  <= '0;
      pout_reg  <= '0;
      drive_reg <= 1'h0;
    end else if (run) begin
      if (rd_ready) begin
        dout_reg <= rd_word;
        pout_reg <= rd_par;
      end
      drive_reg <= drive_next;
    end
  end

  // Drive only on a read slot with output enable low
  wire drive_n = !(drive_reg && !oe_n_reg);

  assign data_lines_o        = dout_reg;
  assign parity_lines_o      = pout_reg;
  assign data_lines_oe_n_o   = drive_n;
  assign parity_lines_oe_n_o = drive_n;

endmodule

// File: tb/sram_port_sva.sv
// Checker for the SRAM port: drive direction, pipeline slots and freeze.
// Assumes a bind to sram_port; every input mirrors a design pin.
`timescale 1ns/10ps
module sram_port_sva
  import sram_port_pkg::*;
(
  input wire logic              sys_clk_i,           // Clock
  input wire logic              rst_n_i,             // Reset
  input wire logic              clock_qualify_n_i,   // Qualify
  input wire logic              chip_select_low_a_i, // Select a
  input wire logic              chip_select_high_i,  // Select high
  input wire logic              chip_select_low_b_i, // Select b
  input wire logic              advance_or_load_i,   // Advance
  input wire logic              write_n_i,           // Write
  input wire logic              output_enable_n_i,   // Output enable
  input wire logic              sleep_request_i,     // Sleep
  input wire logic [DATA_W-1:0] data_lines_o,        // Data out
  input wire logic              data_lines_oe_n_o,   // Data drive
  input wire logic [LANES-1:0]  parity_lines_o,      // Parity out
  input wire logic              parity_lines_oe_n_o  // Parity drive
);
  logic [3:0] quiet_reg;
  wire        go  = !clock_qualify_n_i;
  wire        sel = !chip_select_low_a_i && chip_select_high_i && !chip_select_low_b_i;
  wire        ld  = go && !advance_or_load_i;
  // Counts cycles with output enable low and no sleep, saturating
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) quiet_reg <= 4'h0;
    else if (output_enable_n_i || sleep_request_i) quiet_reg <= 4'h0;
    else if (quiet_reg != 4'hF) quiet_reg <= quiet_reg + 4'h1;
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  // Two running cycles carry a slot onto the lines
  sequence s_lands;
    go ##1 go;
  endsequence
  sequence s_rd_pair;
    (ld && sel && write_n_i) ##1 (go && (advance_or_load_i || (sel && write_n_i)));
  endsequence
  a_read_drives: assert property (
    s_rd_pair ##1 s_lands ##0 (quiet_reg > 4'h9) |=> !data_lines_oe_n_o)
    else $error("read slot was not driven");
  a_desel_floats: assert property (
    (ld && !sel) ##1 s_lands |=> data_lines_oe_n_o)
    else $error("deselect slot was driven");
  a_write_floats: assert property (
    (ld && sel && !write_n_i) ##1 s_lands |=> data_lines_oe_n_o)
    else $error("write data slot was driven");
  a_oe_blocks: assert property (
    output_enable_n_i [*8] |-> data_lines_oe_n_o && parity_lines_oe_n_o)
    else $error("lines driven with output enable high");
  a_par_oe_same: assert property (
    data_lines_oe_n_o == parity_lines_oe_n_o)
    else $error("parity drive differs from data drive");
  a_hold_data: assert property (
    clock_qualify_n_i |-> ##2 $stable(data_lines_o))
    else $error("data out moved while frozen");
  a_hold_par: assert property (
    clock_qualify_n_i |-> ##2 $stable(parity_lines_o))
    else $error("parity out moved while frozen");
  a_sleep_floats: assert property (
    sleep_request_i [*8] |-> data_lines_oe_n_o)
    else $error("lines driven while asleep");
endmodule

// File: tb/ctrl_model.sv
// Controller side model: drives write data and resolves the shared lines.
// Assumes the bench says when to drive; a floating bus shows a toggling pattern.
`timescale 1ns/10ps
module ctrl_model
  import sram_port_pkg::*;
(
  input  wire logic              sys_clk_i,   // Clock
  input  wire logic              drv_i,       // Drive write data now
  input  wire logic [DATA_W-1:0] wdata_i,     // Write data
  input  wire logic [LANES-1:0]  wpar_i,      // Write parity
  input  wire logic [DATA_W-1:0] dev_data_i,  // Device data
  input  wire logic [LANES-1:0]  dev_par_i,   // Device parity
  input  wire logic              dev_oe_n_i,  // Device data drive
  input  wire logic              dev_poe_n_i, // Device parity drive
  output logic      [DATA_W-1:0] bus_data_o,  // Resolved data lines
  output logic      [LANES-1:0]  bus_par_o    // Resolved parity lines
);
  logic [DATA_W-1:0] last_data_reg = 32'h5A5A_5A5A;
  logic [LANES-1:0]  last_par_reg  = 4'h5;
  // Keep the last level so an undriven line shows its inverse
  always @(posedge sys_clk_i) begin
    last_data_reg <= bus_data_o;
    last_par_reg  <= bus_par_o;
  end
  // Write data only when told, on the data phase edge; contention is unknown
  assign bus_data_o = (!dev_oe_n_i && drv_i) ? 'x : !dev_oe_n_i ? dev_data_i :
                      drv_i ? wdata_i : ~last_data_reg;
  assign bus_par_o  = (!dev_poe_n_i && drv_i) ? 'x : !dev_poe_n_i ? dev_par_i :
                      drv_i ? wpar_i : ~last_par_reg;
endmodule

// File: tb/tb.sv
// Testbench for the SRAM port: scripted pin cycles against the controller model.
// Assumes package, design, checker and model are compiled before this file.
`timescale 1ns/10ps
module tb
  import sram_port_pkg::*;
;
  logic              sys_clk_i, rst_n_i, q_n, cs_a, cs_h, cs_b, adv, we_n;
  logic              oe_n, mode, zz, drv, doe_n, poe_n;
  logic [LANES-1:0]  bw_n, wp, bus_p, dpar;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wd, bus_d, ddat;
  int                err_total, n_checks, cyc;
  wire  [36:0]       seen = {doe_n, dpar, ddat};
  sram_port uut (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .clock_qualify_n_i(q_n),
    .chip_select_low_a_i(cs_a), .chip_select_high_i(cs_h), .chip_select_low_b_i(cs_b),
    .advance_or_load_i(adv), .write_n_i(we_n), .byte_lane_write_n_i(bw_n), .addr_i(addr),
    .output_enable_n_i(oe_n), .burst_order_i(mode), .sleep_request_i(zz),
    .data_lines_i(bus_d), .data_lines_o(ddat), .data_lines_oe_n_o(doe_n),
    .parity_lines_i(bus_p), .parity_lines_o(dpar), .parity_lines_oe_n_o(poe_n));
  ctrl_model model (.sys_clk_i(sys_clk_i), .drv_i(drv), .wdata_i(wd), .wpar_i(wp),
    .dev_data_i(ddat), .dev_par_i(dpar), .dev_oe_n_i(doe_n), .dev_poe_n_i(poe_n),
    .bus_data_o(bus_d), .bus_par_o(bus_p));
  // Free running 250 MHz clock
  initial begin
    sys_clk_i = 1'b0;
    forever #2 sys_clk_i = ~sys_clk_i;
  end
  // Cycle ceiling cuts a hung run short
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 1000) begin
      err_total++;
      stop_test();
    end
  end
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [36:0] seen_v, input logic [36:0] exp_v);
    n_checks++;
    if (seen_v !== exp_v) begin
      err_total++;
      $display("[FAIL] %0t ns: seen %h, expected %h", $time, seen_v, exp_v);
    end
  endtask
  // One pin cycle: selects, address and command with the address, data for two back
  task automatic step(input logic [2:0] en, input logic a, input logic w, input logic [3:0] b,
                      input logic [ADDR_W-1:0] ad, input logic dr, input logic [DATA_W-1:0] d,
                      input logic [3:0] p);
    {cs_a, cs_h, cs_b, adv, we_n} = {!en[0], en[1], !en[2], a, w};
    {bw_n, addr, drv, wd, wp} = {b, ad, dr, d, p};
    @(posedge sys_clk_i);
    #1;
  endtask
  task automatic idle(input int n);
    repeat (n) step(3'h0, 1'b0, 1'b1, 4'hF, 17'h0, 1'b0, 32'h0, 4'h0);
  endtask
  task automatic rd2(input logic [ADDR_W-1:0] ad);
    step(3'h7, 1'b0, 1'b1, 4'hF, ad, 1'b0, 32'h0, 4'h0);
    step(3'h7, 1'b0, 1'b1, 4'hF, ad, 1'b0, 32'h0, 4'h0);
    idle(2);
  endtask
  function automatic logic [DATA_W-1:0] word(input int k);
    return 32'h1111_1111 * 32'(k + 1);
  endfunction
  function automatic logic [3:0] par(input int k);
    return 4'(k + 5);
  endfunction
  // Linear write burst from offset 1, read back as an interleaved burst
  task automatic t_burst;
    int k;
    mode = 1'b0;
    idle(8);
    for (int i = 0; i < 6; i++) begin
      step(i < 4 ? 3'h7 : 3'h0, i inside {[1:3]}, 1'b0, 4'h0, 17'h21, i >= 2,
           word(i - 2), par(i - 2));
    end
    mode = 1'b1;
    idle(8);
    for (int i = 0; i < 6; i++) begin
      step(i < 4 ? 3'h7 : 3'h0, i inside {[1:3]}, 1'b1, 4'hF, 17'h21, 1'b0, 32'h0, 4'h0);
      k = (((i - 2) ^ 1) + 3) % 4;
      if (i == 2) chk(37'(doe_n), 37'h1);
      if (i > 2) chk(seen, {1'b0, par(k), word(k)});
    end
  endtask
  // Full write then a two-lane partial write, back to back
  task automatic t_partial;
    step(3'h7, 1'b0, 1'b0, 4'h0, 17'h10, 1'b0, 32'h0, 4'h0);
    step(3'h7, 1'b0, 1'b0, 4'hA, 17'h10, 1'b0, 32'h0, 4'h0);
    step(3'h0, 1'b0, 1'b1, 4'hF, 17'h0, 1'b1, 32'hFFFF_FFFF, 4'hF);
    step(3'h0, 1'b0, 1'b1, 4'hF, 17'h0, 1'b1, 32'h0, 4'h0);
    rd2(17'h10);
    chk(seen, {1'b0, 4'hA, 32'hFF00_FF00});
    // Write then read of the same word on the next edge
    step(3'h7, 1'b0, 1'b0, 4'h0, 17'h30, 1'b0, 32'h0, 4'h0);
    step(3'h7, 1'b0, 1'b1, 4'hF, 17'h30, 1'b0, 32'h0, 4'h0);
    step(3'h0, 1'b0, 1'b1, 4'hF, 17'h0, 1'b1, 32'hC3C3_3C3C, 4'h9);
    idle(1);
    chk(seen, {1'b0, 4'h9, 32'hC3C3_3C3C});
    idle(1);
  endtask
  // Each chip select alone inactive deselects the cycle after the second read
  task automatic t_select;
    for (int k = 0; k < 3; k++) begin
      step(3'h7, 1'b0, 1'b1, 4'hF, 17'h10, 1'b0, 32'h0, 4'h0);
      step(3'h7, 1'b0, 1'b1, 4'hF, 17'h10, 1'b0, 32'h0, 4'h0);
      step(3'h7 ^ (3'h1 << k), 1'b0, 1'b1, 4'hF, 17'h10, 1'b0, 32'h0, 4'h0);
      idle(1);
      chk(37'(doe_n), 37'h0);
      idle(1);
      chk(37'(doe_n), 37'h1);
      idle(1);
    end
  endtask
  // Qualify held high in mid read; the read must still land afterwards
  task automatic t_freeze;
    step(3'h7, 1'b0, 1'b1, 4'hF, 17'h10, 1'b0, 32'h0, 4'h0);
    step(3'h7, 1'b0, 1'b1, 4'hF, 17'h10, 1'b0, 32'h0, 4'h0);
    q_n = 1'b1;
    idle(3);
    q_n = 1'b0;
    idle(2);
    chk(seen, {1'b0, 4'hA, 32'hFF00_FF00});
  endtask
  task automatic t_oe;
    oe_n = 1'b1;
    idle(8);
    rd2(17'h10);
    chk(37'(doe_n), 37'h1);
    oe_n = 1'b0;
    idle(8);
  endtask
  // A write tried while asleep is ignored and the array keeps its word
  task automatic t_sleep;
    zz = 1'b1;
    idle(6);
    step(3'h7, 1'b0, 1'b0, 4'h0, 17'h10, 1'b0, 32'h0, 4'h0);
    idle(1);
    step(3'h0, 1'b0, 1'b1, 4'hF, 17'h0, 1'b1, 32'h0, 4'h0);
    zz = 1'b0;
    idle(10);
    rd2(17'h10);
    chk(seen, {1'b0, 4'hA, 32'hFF00_FF00});
  endtask
  // Reset for 4 cycles, then every scenario in turn
  initial begin
    rst_n_i = 1'b0;
    {q_n, oe_n, mode, zz} = 4'h2;
    idle(4);
    rst_n_i = 1'b1;
    idle(4);
    t_burst();
    t_partial();
    t_select();
    t_freeze();
    t_oe();
    t_sleep();
    stop_test();
  end
endmodule
bind sram_port sram_port_sva chk_i (
  .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .clock_qualify_n_i(clock_qualify_n_i),
  .chip_select_low_a_i(chip_select_low_a_i), .chip_select_high_i(chip_select_high_i),
  .chip_select_low_b_i(chip_select_low_b_i), .advance_or_load_i(advance_or_load_i),
  .write_n_i(write_n_i), .output_enable_n_i(output_enable_n_i),
  .sleep_request_i(sleep_request_i), .data_lines_o(data_lines_o),
  .data_lines_oe_n_o(data_lines_oe_n_o), .parity_lines_o(parity_lines_o),
  .parity_lines_oe_n_o(parity_lines_oe_n_o));
